/* core/lsr_core.sv */
// Two-channel light sensor readout: converter sequencer and result/interrupt logic
// Notes on behaviour
// - Both channels integrate over one shared period
// - Channel results land in their own registers
// - Results swap whole, never mixed with old
// - Next integration restarts automatically after transfer
// - Each channel reads as a 16-bit value
// - Serial port at most 100 or 400 kHz
// - Gain and integration time steer each conversion
// - Lower and upper thresholds form a window
// - Channel-zero result outside window raises an interrupt
// - Persistence count gates the interrupt
// - Level interrupt holds until firmware clears
// - SMBus variant signals through the alert mechanism
// - Interrupt pin is open drain, low when active
// - Three-state address pin picks the slave address
// - Power-down stops all conversion activity
// - Counts saturate at full scale per integration time
`timescale 1ns/100ps
module lsr_core #(
  parameter int         OSC_KHZ     = 735,
  parameter int         BUS_KHZ     = lsr_pkg::I2C_MAX_KHZ,
  parameter bit         SMB_VARIANT = 1'b0,
  parameter int         TINT0_CYC   = lsr_pkg::TINT_SHORT_TMS * OSC_KHZ / lsr_pkg::TMS_PER_KHZ,
  parameter int         TINT1_CYC   = lsr_pkg::TINT_MED_TMS * OSC_KHZ / lsr_pkg::TMS_PER_KHZ,
  parameter int         TINT2_CYC   = lsr_pkg::TINT_LONG_TMS * OSC_KHZ / lsr_pkg::TMS_PER_KHZ,
  // Slave addresses per address pin state; values are arbitrary
  parameter logic [6:0] ADDR_LOW    = 7'h10,
  parameter logic [6:0] ADDR_FLOAT  = 7'h20,
  parameter logic [6:0] ADDR_HIGH   = 7'h30
) (
  // System clock and reset
  input  wire logic        CLK_I,
  input  wire logic        NRST_I,
  // Converter oscillator domain
  input  wire logic        OSC_CLK_I,
  input  wire logic [1:0]  CONV_PULSE_I,
  // Configuration
  input  wire logic        PWR_ON_I,
  input  wire logic        GAIN_HI_I,
  input  wire logic [1:0]  TINT_SEL_I,
  input  wire logic [15:0] TH_LO_I,
  input  wire logic [15:0] TH_HI_I,
  input  wire logic [3:0]  PERSIST_I,
  input  wire logic        INT_EN_I,
  // Serial engine side
  input  wire logic        HOLD_I,
  input  wire logic        INT_CLR_I,
  input  wire logic        ARA_ACK_I,
  // Address select pad
  input  wire logic        ADDR_SEL_I,
  input  wire logic        ADDR_FLOAT_I,
  // Results
  output logic      [15:0] CH0_DATA_O,
  output logic      [15:0] CH1_DATA_O,
  output logic             NEW_DATA_O,
  output logic      [6:0]  SLAVE_ADDR_O,
  output logic             ADDR_VALID_O,
  // Open-drain interrupt pin
  output logic             INT_O,
  output logic             INT_OE_O
);
  localparam int CW = lsr_pkg::CNT_W;
  // Elaboration checks
  if (TINT0_CYC < 1 || TINT2_CYC >= (1 << CW) || TINT0_CYC > TINT1_CYC
      || TINT1_CYC > TINT2_CYC) begin : g_bad_tint
    $error("Integration counts out of range");
  end
  if (BUS_KHZ > (SMB_VARIANT ? lsr_pkg::SMB_MAX_KHZ : lsr_pkg::I2C_MAX_KHZ)
      || lsr_pkg::CLK_KHZ < lsr_pkg::MIN_OVERSAMPLE * BUS_KHZ) begin : g_bad_bus
    $error("Serial rate not served by this variant");
  end
  function automatic logic [CW-1:0] last_cyc(input logic [1:0] sel);
    case (sel)
      lsr_pkg::TINT_SHORT: last_cyc = CW'(TINT0_CYC - 1);
      lsr_pkg::TINT_MED:   last_cyc = CW'(TINT1_CYC - 1);
      default:             last_cyc = CW'(TINT2_CYC - 1);
    endcase
  endfunction : last_cyc
  function automatic logic [16:0] full_scale(input logic [1:0] sel);
    case (sel)
      lsr_pkg::TINT_SHORT: full_scale = lsr_pkg::FS_SHORT;
      lsr_pkg::TINT_MED:   full_scale = lsr_pkg::FS_MED;
      default:             full_scale = lsr_pkg::FS_LONG;
    endcase
  endfunction : full_scale
  // ---------------- Oscillator domain ----------------
  logic              orst_s1_r;
  logic              orst_n_r;
  logic [3:0]        cfg_s1_r;
  logic [3:0]        cfg_s2_r;
  logic              pwr_s;
  lsr_pkg::lsr_cv_t  cv_r;
  logic [1:0]        tint_q_r;
  logic              gain_q_r;
  logic [CW-1:0]     cnt_r;
  logic              int_end;
  logic              clr_acc;
  logic [16:0]       acc_r [2];
  logic [15:0]       res_r [2];
  logic              done_tgl_r;
  // Reset reaches this domain through its own synchroniser
  always_ff @(posedge OSC_CLK_I) begin
    orst_s1_r <= NRST_I;
    orst_n_r  <= orst_s1_r;
  end
  // Static settings; gain and integration time taken only at period start, power at once
  always_ff @(posedge OSC_CLK_I) begin
    cfg_s1_r <= {PWR_ON_I, GAIN_HI_I, TINT_SEL_I};
    cfg_s2_r <= cfg_s1_r;
  end
  assign pwr_s   = cfg_s2_r[3];
  assign int_end = (cv_r == lsr_pkg::CV_INTEG) && (cnt_r == last_cyc(tint_q_r));
  assign clr_acc = (cv_r != lsr_pkg::CV_INTEG) || !pwr_s || int_end;
  always_ff @(posedge OSC_CLK_I) begin
    if (!orst_n_r) begin
      cv_r     <= lsr_pkg::CV_OFF;
      tint_q_r <= lsr_pkg::TINT_SHORT;
      gain_q_r <= 1'b0;
    end else begin
      case (cv_r)
        lsr_pkg::CV_OFF: begin
          if (pwr_s) begin
            cv_r     <= lsr_pkg::CV_INTEG;
            tint_q_r <= cfg_s2_r[1:0];
            gain_q_r <= cfg_s2_r[2];
          end
        end
        lsr_pkg::CV_INTEG: begin
          if (!pwr_s) begin
            cv_r <= lsr_pkg::CV_OFF;
          end else if (int_end) begin
            tint_q_r <= cfg_s2_r[1:0];
            gain_q_r <= cfg_s2_r[2];
          end
        end
        default: cv_r <= lsr_pkg::CV_OFF;
      endcase
    end
  end
  // One period counter serves both channels
  always_ff @(posedge OSC_CLK_I) begin
    if (!orst_n_r || clr_acc) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + CW'(1);
    end
  end
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic        p_s1_r;
    logic        p_s2_r;
    logic        p_s3_r;
    logic [17:0] sum;
    logic [16:0] fs;
    assign fs  = full_scale(tint_q_r);
    assign sum = {1'b0, acc_r[ch]} + {1'b0, gain_q_r ? lsr_pkg::GAIN_HI_W : lsr_pkg::GAIN_LO_W};
    always_ff @(posedge OSC_CLK_I) begin
      p_s1_r <= CONV_PULSE_I[ch];
      p_s2_r <= p_s1_r;
      p_s3_r <= p_s2_r;
    end
    always_ff @(posedge OSC_CLK_I) begin
      if (!orst_n_r || clr_acc) begin
        acc_r[ch] <= '0;
      end else if (p_s2_r && !p_s3_r) begin
        acc_r[ch] <= (sum > {1'b0, fs}) ? fs : sum[16:0];
      end
    end
    always_ff @(posedge OSC_CLK_I) begin
      if (!orst_n_r) begin
        res_r[ch] <= lsr_pkg::DATA_RST;
      end else if (int_end) begin
        res_r[ch] <= acc_r[ch][15:0];
      end
    end
  end
  always_ff @(posedge OSC_CLK_I) begin
    if (!orst_n_r) begin
      done_tgl_r <= 1'b0;
    end else if (int_end) begin
      done_tgl_r <= !done_tgl_r;
    end
  end
  // ---------------- System clock domain ----------------
  logic       tg_s1_r;
  logic       tg_s2_r;
  logic       tg_s3_r;
  logic       new_ev;
  logic       upd_pend_r;
  logic       xfer;
  logic [15:0] ch0_r;
  logic [15:0] ch1_r;
  logic       new_r;
  logic       oow;
  logic [3:0] pcnt_r;
  logic [4:0] pcnt_inc;
  logic       fire;
  logic       int_clr;
  logic       pend_r;
  logic [1:0] ad_s1_r;
  logic [1:0] ad_s2_r;
  logic [1:0] ad_cnt_r;
  logic [6:0] addr_r;
  logic       addr_ok_r;
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      tg_s1_r <= 1'b0;
      tg_s2_r <= 1'b0;
      tg_s3_r <= 1'b0;
    end else begin
      tg_s1_r <= done_tgl_r;
      tg_s2_r <= tg_s1_r;
      tg_s3_r <= tg_s2_r;
    end
  end
  assign new_ev = tg_s2_r ^ tg_s3_r;
  // A held read defers the swap; source words stay put for a whole period
  assign xfer = (new_ev || upd_pend_r) && !HOLD_I;
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      upd_pend_r <= 1'b0;
    end else begin
      upd_pend_r <= (new_ev || upd_pend_r) && HOLD_I;
    end
  end
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      ch0_r <= lsr_pkg::DATA_RST;
      ch1_r <= lsr_pkg::DATA_RST;
      new_r <= 1'b0;
    end else begin
      new_r <= xfer;
      if (xfer) begin
        ch0_r <= res_r[0];
        ch1_r <= res_r[1];
      end
    end
  end
  // Window test on the channel-zero result being transferred
  assign oow      = (res_r[0] < TH_LO_I) || (res_r[0] > TH_HI_I);
  assign pcnt_inc = {1'b0, pcnt_r} + 5'h01;
  assign fire     = INT_EN_I && xfer
                    && ((PERSIST_I == 4'h0) || (oow && (pcnt_inc >= {1'b0, PERSIST_I})));
  assign int_clr  = INT_CLR_I || (SMB_VARIANT && ARA_ACK_I);
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      pcnt_r <= 4'h0;
    end else if (xfer) begin
      pcnt_r <= !oow ? 4'h0 : (pcnt_r == lsr_pkg::PCNT_MAX) ? pcnt_r : pcnt_inc[3:0];
    end
  end
  // A new event beats a clear in the same cycle
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      pend_r <= 1'b0;
    end else begin
      pend_r <= fire || (pend_r && !int_clr);
    end
  end

  always_ff @(posedge CLK_I) begin
    ad_s1_r <= {ADDR_FLOAT_I, ADDR_SEL_I};
    ad_s2_r <= ad_s1_r;
  end
  // Pad caught once, after the synchroniser has settled
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      ad_cnt_r  <= 2'h0;
      addr_r    <= ADDR_LOW;
      addr_ok_r <= 1'b0;
    end else if (!addr_ok_r) begin
      if (ad_cnt_r == lsr_pkg::ADDR_SETTLE) begin
        addr_ok_r <= 1'b1;
        addr_r    <= ad_s2_r[1] ? ADDR_FLOAT : ad_s2_r[0] ? ADDR_HIGH : ADDR_LOW;
      end else begin
        ad_cnt_r <= ad_cnt_r + 2'h1;
      end
    end
  end

  assign CH0_DATA_O   = ch0_r;
  assign CH1_DATA_O   = ch1_r;
  assign NEW_DATA_O   = new_r;
  assign SLAVE_ADDR_O = addr_r;
  assign ADDR_VALID_O = addr_ok_r;
  assign INT_OE_O     = pend_r;
  assign INT_O        = 1'b0;
  // ---------------- Assertions ----------------
  AST_SWAP_ONLY: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (!$stable(ch0_r) || !$stable(ch1_r)) |-> $past(xfer))
    else $error("Data changed without a transfer");
  AST_HOLD_FREEZE: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    HOLD_I |=> ($stable(ch0_r) && $stable(ch1_r)))
    else $error("Data changed during a held read");
  AST_CH_MAP: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    xfer |=> (ch0_r == $past(res_r[0])) && (ch1_r == $past(res_r[1])))
    else $error("Channel results misplaced");
  AST_NEW_PULSE: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    new_ev && !HOLD_I |=> NEW_DATA_O ##1 !NEW_DATA_O)
    else $error("New data pulse wrong");
  AST_RESTART: assert property (@(posedge OSC_CLK_I) disable iff (!orst_n_r)
    (cnt_r == '0) |-> (acc_r[0] == '0) && (acc_r[1] == '0))
    else $error("Channels not started together");
  AST_PERIOD: assert property (@(posedge OSC_CLK_I) disable iff (!orst_n_r)
    int_end && pwr_s |=> (cv_r == lsr_pkg::CV_INTEG) && (cnt_r == '0))
    else $error("Next integration did not restart");
  AST_SAT: assert property (@(posedge OSC_CLK_I) disable iff (!orst_n_r || !NRST_I)
    (acc_r[0] <= full_scale(tint_q_r)) && (acc_r[1] <= full_scale(tint_q_r)))
    else $error("Count above full scale");
  AST_PWDN: assert property (@(posedge OSC_CLK_I) disable iff (!orst_n_r)
    !pwr_s |=> (cnt_r == '0) && (acc_r[0] == '0) && !int_end)
    else $error("Conversion active in power-down");
  AST_INT_SET: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    fire |=> INT_OE_O && !INT_O)
    else $error("Interrupt not raised");
  AST_INT_KEEP: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    INT_OE_O && !int_clr |=> INT_OE_O)
    else $error("Interrupt dropped without a clear");
  AST_PERSIST: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    xfer && !oow && (PERSIST_I != 4'h0) |-> !fire)
    else $error("In-window result fired");
  AST_ADDR_HOLD: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    ADDR_VALID_O |=> ADDR_VALID_O && $stable(SLAVE_ADDR_O))
    else $error("Slave address moved");

  COV_XFER: cover property (@(posedge CLK_I) disable iff (!NRST_I) xfer);
  COV_DEFER: cover property (@(posedge CLK_I) disable iff (!NRST_I) new_ev && HOLD_I);
  COV_FIRE: cover property (@(posedge CLK_I) disable iff (!NRST_I) fire && !pend_r);
  COV_PWDN: cover property (@(posedge OSC_CLK_I) disable iff (!orst_n_r)
    (cv_r == lsr_pkg::CV_INTEG) ##1 (cv_r == lsr_pkg::CV_OFF));
endmodule : lsr_core

/* shared/lsr_pkg.sv */
// Constants and types shared by the light sensor readout core
package lsr_pkg;
  // Integration time select codes
  localparam logic [1:0]  TINT_SHORT     = 2'h0;
  localparam logic [1:0]  TINT_MED       = 2'h1;
  localparam logic [1:0]  TINT_LONG      = 2'h2;
  // Integration times in tenths of a millisecond
  localparam int          TINT_SHORT_TMS = 137;
  localparam int          TINT_MED_TMS   = 1010;
  localparam int          TINT_LONG_TMS  = 4020;
  localparam int          TMS_PER_KHZ    = 10;
  // Full-scale counts per integration time
  localparam logic [16:0] FS_SHORT       = 17'h013B7;
  localparam logic [16:0] FS_MED         = 17'h09139;
  localparam logic [16:0] FS_LONG        = 17'h0FFFF;
  // Count weight per converter quantum at low and high gain
  localparam logic [16:0] GAIN_LO_W      = 17'h00001;
  localparam logic [16:0] GAIN_HI_W      = 17'h00010;
  // Serial port rates and system clock
  localparam int          SMB_MAX_KHZ    = 100;
  localparam int          I2C_MAX_KHZ    = 400;
  localparam int          CLK_KHZ        = 40000;
  localparam int          MIN_OVERSAMPLE = 8;
  // Widths and reset values
  localparam int          CNT_W          = 19;
  localparam logic [15:0] DATA_RST       = 16'h0000;
  localparam logic [3:0]  PCNT_MAX       = 4'hF;
  localparam logic [1:0]  ADDR_SETTLE    = 2'h3;
  // Converter sequencer states
  typedef enum logic [0:0] {CV_OFF, CV_INTEG} lsr_cv_t;
endpackage : lsr_pkg

/* tb/lsr_light_model.sv */
// Behavioural photodiode front end that feeds converter quanta
`timescale 1ns/100ps
module lsr_light_model (
  // Oscillator and burst request
  input  wire logic       osc_clk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] n0_i,
  input  wire logic [7:0] n1_i,
  // Quanta towards the core
  output logic      [1:0] pulse_o
);
  initial pulse_o = 2'h0;
  // Each level lasts two oscillator periods so the synchroniser never misses one
  task automatic burst(input int ch, input int n);
    repeat (n) begin
      @(posedge osc_clk_i);
      pulse_o[ch] <= 1'b1;
      repeat (2) @(posedge osc_clk_i);
      pulse_o[ch] <= 1'b0;
      @(posedge osc_clk_i);
    end
  endtask : burst
  always @(posedge go_i) begin
    fork
      burst(0, int'(n0_i));
      burst(1, int'(n1_i));
    join
  end
endmodule : lsr_light_model

/* tb/lsr_core_tb.sv */
// Self-checking bench for the light sensor readout core
`timescale 1ns/100ps
module lsr_core_tb;
  localparam int T0 = 60;
  localparam int T1 = 120;
  localparam int T2 = 200;
  typedef struct {logic g; logic [1:0] t; logic [7:0] n0; logic [7:0] n1; logic [15:0] hi;} lsr_row_t;
  lsr_row_t rows [4] = '{'{1'b0, 2'h0, 8'h0D, 8'h02, 16'hFFFF}, '{1'b1, 2'h1, 8'h14, 8'h1C, 16'h0064},
                          '{1'b0, 2'h2, 8'h2D, 8'h01, 16'h002C}, '{1'b1, 2'h3, 8'h05, 8'h00, 16'hFFFF}};
  logic clk = 1'b0, osc = 1'b0, nrst = 1'b0, pwr = 1'b1, gain = 1'b0, int_en = 1'b1;
  logic hold = 1'b0, clr = 1'b0, go = 1'b0, asel = 1'b0, aflt = 1'b0, ara = 1'b0;
  logic [1:0] tint = 2'h0, pulse;
  logic [3:0] pers = 4'h1;
  logic [7:0] n0 = 8'h00, n1 = 8'h00;
  logic [15:0] th_lo = 16'h0000, th_hi = 16'hFFFF, ch0, ch1, w;
  logic nd, aval, int_o, int_oe;
  logic [6:0] saddr;
  int num_errors = 0, checks_done = 0, cyc = 0, nd_cnt = 0, t_s, tp, base;
  initial forever #12.5 clk = ~clk;
  initial begin
    #7.3;
    forever #62.5 osc = ~osc;
  end
  lsr_light_model lsr_light_model_i (.osc_clk_i(osc), .go_i(go), .n0_i(n0), .n1_i(n1),
                                     .pulse_o(pulse));
  lsr_core #(.TINT0_CYC(T0), .TINT1_CYC(T1), .TINT2_CYC(T2)) lsr_core_i (
    .CLK_I(clk), .NRST_I(nrst), .OSC_CLK_I(osc), .CONV_PULSE_I(pulse), .PWR_ON_I(pwr),
    .GAIN_HI_I(gain), .TINT_SEL_I(tint), .TH_LO_I(th_lo), .TH_HI_I(th_hi), .PERSIST_I(pers),
    .INT_EN_I(int_en), .HOLD_I(hold), .INT_CLR_I(clr), .ARA_ACK_I(ara), .ADDR_SEL_I(asel),
    .ADDR_FLOAT_I(aflt), .CH0_DATA_O(ch0), .CH1_DATA_O(ch1), .NEW_DATA_O(nd),
    .SLAVE_ADDR_O(saddr), .ADDR_VALID_O(aval), .INT_O(int_o), .INT_OE_O(int_oe));
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (nd === 1'b1) nd_cnt <= nd_cnt + 1;
    if (cyc == 60000) begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] s);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk16
  task automatic chk_rng(input string nm, input int e, input int s);
    checks_done++;
    if (s < e - 3 || s > e + 3) begin
      num_errors++;
      $display("Error %s expected %0d seen %0d", nm, e, s);
    end
  endtask : chk_rng
  task automatic wait_nd();
    int k;
    k = 0;
    @(negedge clk);
    while (nd !== 1'b1 && k < 1200) begin
      @(negedge clk);
      k++;
    end
    chk16("new_data", 16'h0001, {15'h0000, nd});
  endtask : wait_nd
  task automatic pulse_clr();
    clr = 1'b1;
    @(negedge clk);
    clr = 1'b0;
  endtask : pulse_clr
  initial begin
    repeat (24) @(negedge clk);
    nrst = 1'b1;
    foreach (rows[r]) begin
      gain = rows[r].g;
      tint = rows[r].t;
      th_hi = rows[r].hi;
      wait_nd();
      wait_nd();
      t_s = cyc;
      pulse_clr();
      n0 = rows[r].n0;
      n1 = rows[r].n1;
      go = 1'b1;
      wait_nd();
      go = 1'b0;
      w = gain ? 16'h0010 : 16'h0001;
      tp = (tint == 2'h0) ? T0 : (tint == 2'h1) ? T1 : T2;
      chk_rng("period", tp * 5, cyc - t_s);
      chk16("ch0", 16'(n0) * w, ch0);
      chk16("ch1", 16'(n1) * w, ch1);
      chk16("int_oe", {15'h0000, (16'(n0) * w) > th_hi}, {15'h0000, int_oe});
      chk16("int_o", 16'h0000, {15'h0000, int_o});
      $display("Row %0d done", r);
    end
    // Persistence, level hold and clear
    th_hi = 16'hFFFF;
    pers = 4'h0;
    wait_nd();
    chk16("int_oe", 16'h0001, {15'h0000, int_oe});
    pers = 4'h2;
    wait_nd();
    pulse_clr();
    th_lo = 16'h000A;
    wait_nd();
    chk16("int_oe", 16'h0000, {15'h0000, int_oe});
    wait_nd();
    chk16("int_oe", 16'h0001, {15'h0000, int_oe});
    repeat (10) @(negedge clk);
    chk16("int_oe", 16'h0001, {15'h0000, int_oe});
    ara = 1'b1;
    @(negedge clk);
    ara = 1'b0;
    chk16("int_oe", 16'h0001, {15'h0000, int_oe});
    chk16("ch0", 16'h0000, ch0);
    pulse_clr();
    chk16("int_oe", 16'h0000, {15'h0000, int_oe});
    int_en = 1'b0;
    wait_nd();
    wait_nd();
    chk16("int_oe", 16'h0000, {15'h0000, int_oe});
    $display("Interrupt test done");
    // Results held back while the serial engine reads
    tint = 2'h0;
    wait_nd();
    wait_nd();
    n0 = 8'h07;
    n1 = 8'h09;
    go = 1'b1;
    repeat (150) @(negedge clk);
    go = 1'b0;
    hold = 1'b1;
    base = nd_cnt;
    repeat (200) @(negedge clk);
    chk16("held_nd", 16'(base), 16'(nd_cnt));
    chk16("held_ch0", 16'h0000, ch0);
    hold = 1'b0;
    wait_nd();
    chk16("ch0", 16'h0070, ch0);
    chk16("ch1", 16'h0090, ch1);
    $display("Hold test done");
    // Power-down stops conversions
    pwr = 1'b0;
    repeat (20) @(negedge clk);
    base = nd_cnt;
    repeat (T2 * 10) @(negedge clk);
    chk16("pd_nd", 16'(base), 16'(nd_cnt));
    pwr = 1'b1;
    wait_nd();
    $display("Power-down test done");
    // Address pad states, each caught after a reset
    for (int s = 0; s < 3; s++) begin
      aflt = (s == 2);
      asel = (s == 1);
      nrst = 1'b0;
      repeat (24) @(negedge clk);
      chk16("rst_ch0", 16'h0000, ch0);
      chk16("rst_int", 16'h0000, {15'h0000, int_oe});
      nrst = 1'b1;
      repeat (3) @(negedge clk);
      chk16("aval", 16'h0000, {15'h0000, aval});
      @(negedge clk);
      chk16("aval", 16'h0001, {15'h0000, aval});
      asel = ~asel;
      repeat (4) @(negedge clk);
      chk16("addr", (s == 0) ? 16'h0010 : (s == 1) ? 16'h0030 : 16'h0020, {9'h000, saddr});
    end
    $display("Address test done");
    wrap_up();
  end
endmodule : lsr_core_tb
